// ==== ecr_regs.vh ====
// register offsets, field positions and reset values of the event channel router
`ifndef ECR_REGS_VH
`define ECR_REGS_VH
`define ECR_OFS_GLOBAL_CONTROL     5'h00
`define ECR_OFS_CHANNEL_CONFIG     5'h04
`define ECR_OFS_USER_CHANNEL_MUX   5'h08
`define ECR_OFS_CHANNEL_STATE      5'h0c
`define ECR_OFS_IRQ_ENABLE_CLEAR   5'h10
`define ECR_OFS_IRQ_ENABLE_SET     5'h14
`define ECR_OFS_IRQ_PENDING        5'h18
`define ECR_OFS_ROUTER_ENABLE      5'h1c
`define ECR_BIT_SOFT_RESET         0
`define ECR_BIT_CLOCK_POLICY       4
`define ECR_BIT_SW_EVENT           8
`define ECR_EDGE_HI                27
`define ECR_EDGE_LO                26
`define ECR_PATH_HI                25
`define ECR_PATH_LO                24
`define ECR_GEN_HI                 22
`define ECR_GEN_LO                 16
`define ECR_CHIDX_HI               3
`define ECR_CHIDX_LO               0
`define ECR_EDGE_NONE              2'h0
`define ECR_EDGE_RISE              2'h1
`define ECR_EDGE_FALL              2'h2
`define ECR_EDGE_BOTH              2'h3
`define ECR_PATH_SYNC              2'h0
`define ECR_PATH_RESYNC            2'h1
`define ECR_PATH_ASYNC             2'h2
`define ECR_RESET_WORD             32'h0000_0000
`endif

// ==== ecr_channel.v ====
// per-channel event path: edge detection, status, flags and generic clock request
`timescale 1ns/10ps
module ecr_channel (
   input  wire       clock,
   input  wire       srst,
   input  wire       gen_sig,
   input  wire       sw_event,
   input  wire [1:0] edge_select,
   input  wire [1:0] path_select,
   input  wire       gen_valid,
   input  wire       clock_request_policy,
   input  wire       users_ready,
   input  wire       users_ack,
   output reg        event_out,
   output wire       async_out,
   output reg        channel_busy,
   output wire       detect,
   output wire       overrun,
   output wire       gclk_req
);
   `include "ecr_regs.vh"
   reg  sync_a;
   reg  sync_b;
   reg  prev;
   wire is_async = (path_select == `ECR_PATH_ASYNC);
   // resync path takes the two-flop copy, sync path the raw signal already in domain
   wire cur      = (path_select == `ECR_PATH_RESYNC) ? sync_b : gen_sig;
   reg  edge_hit;
   always @* begin
      case (edge_select)
         `ECR_EDGE_RISE: edge_hit = cur & ~prev;
         `ECR_EDGE_FALL: edge_hit = ~cur & prev;
         `ECR_EDGE_BOTH: edge_hit = cur ^ prev;
         default:        edge_hit = 1'b0;
      endcase
   end
   assign detect   = ~is_async & ((gen_valid & edge_hit) | sw_event);
   assign overrun  = detect & (channel_busy | ~users_ready);
   // async events pass straight through; no clock needed
   assign async_out = is_async & gen_valid & gen_sig;
   assign gclk_req  = ~is_async & gen_valid &
                      (clock_request_policy | detect | channel_busy);
   always @(posedge clock) begin
      if (srst) begin
         sync_a       <= 1'b0;
         sync_b       <= 1'b0;
         prev         <= 1'b0;
         event_out    <= 1'b0;
         channel_busy <= 1'b0;
      end else begin
         sync_a       <= gen_sig;
         sync_b       <= sync_a;
         prev         <= cur;
         event_out    <= detect;
         if (detect)
            channel_busy <= 1'b1;
         else if (users_ack)
            channel_busy <= 1'b0;
      end
   end
endmodule // ecr_channel

// ==== ecr_router.v ====
// event channel router: Avalon-MM register file and twelve channels
//
// Contract
// - byte, halfword and word accesses taken whole, never split.
// - every byte and halfword of a register is addressable alone; a global control write without lane 0 still clears the clock policy bit.
// - enable-protected registers take writes only while the router is disabled.
// - policy bit zero: channel clock requested only when an event is detected; the code also keeps the request up while the channel is busy.
// - policy bit one: configured channel clocks run always; the code requests none for channels on the async path.
// - asynchronous path events propagate with no generic clock.
// - soft reset bit one resets every register; zero does nothing.
// - a write setting soft reset discards its other bits.
// - edge select 0 none, 1 rise, 2 fall, 3 both edges.
// - path 0 sync, 1 resync, 2 async, 3 reserved.
// - generator select picks a generator; zero means none, the reset state.
// - software event bit injects one event on chosen channel; reads zero.
// - busy while event unhandled; user ready when all users accept.
// - interrupt high while any flag set with its enable set.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
module ecr_router #(
   parameter NCH  = 12,
   parameter NGEN = 128
) (
   input  wire              clock,
   input  wire              srst,
   input  wire [4:0]        avs_address,
   input  wire              avs_read,
   input  wire              avs_write,
   input  wire [3:0]        avs_byteenable,
   input  wire [31:0]       avs_writedata,
   output reg  [31:0]       avs_readdata,
   output wire              avs_waitrequest,
   input  wire [NGEN-1:0]   gen_events,
   input  wire [NCH-1:0]    users_ready,
   input  wire [NCH-1:0]    users_ack,
   output wire [NCH-1:0]    channel_event,
   output wire [NCH-1:0]    channel_async,
   output wire [NCH-1:0]    gclk_request,
   output wire              irq
);
   `include "ecr_regs.vh"
   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   reg         done;
   reg  [7:0]  ctrl;
   reg  [3:0]  ch_index;
   reg  [15:0] user_mux;
   reg         router_enable;
   reg  [1:0]  edge_r [0:NCH-1];
   reg  [1:0]  path_r [0:NCH-1];
   reg  [6:0]  gen_r  [0:NCH-1];
   reg  [NCH-1:0] en_ovr;
   reg  [NCH-1:0] en_evd;
   reg  [NCH-1:0] fl_ovr;
   reg  [NCH-1:0] fl_evd;
   wire [NCH-1:0] busy;
   wire [NCH-1:0] det;
   wire [NCH-1:0] overrun_flag;
   // one wait cycle: request taken on the second edge, whole access at once
   assign avs_waitrequest = (avs_read | avs_write) & ~done;
   wire wr = avs_write & done;
   wire rd = avs_read & done;
   // read data are latched in the wait cycle so they stand at the taking edge
   wire rd_load = avs_read & ~done;
   // byte-lane write mask; any lane alone is valid
   wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wd = avs_writedata & wmask;
   wire soft_rst = wr & (avs_address == `ECR_OFS_GLOBAL_CONTROL) &
                   wd[`ECR_BIT_SOFT_RESET];
   wire rst_all = srst | soft_rst;
   wire wr_ok = wr & ~soft_rst;
   wire prot_ok = ~router_enable;
   wire cfg_wr = wr_ok & (avs_address == `ECR_OFS_CHANNEL_CONFIG);
   // index used by this write: new index if its lane is written
   wire [3:0] wr_idx = avs_byteenable[0] ? avs_writedata[`ECR_CHIDX_HI:`ECR_CHIDX_LO]
                                         : ch_index;
   wire [31:0] en_word  = {4'h0, en_evd[11:8], 4'h0, en_ovr[11:8],
                           en_evd[7:0], en_ovr[7:0]};
   wire [31:0] fl_word  = {4'h0, fl_evd[11:8], 4'h0, fl_ovr[11:8],
                           fl_evd[7:0], fl_ovr[7:0]};
   wire [31:0] st_word  = {4'h0, busy[11:8], 4'h0, users_ready[11:8],
                           busy[7:0], users_ready[7:0]};
   // flag/enable words remapped to per-channel vectors
   wire [NCH-1:0] wd_ovr = {wd[19:16], wd[7:0]};
   wire [NCH-1:0] wd_evd = {wd[27:24], wd[15:8]};
   always @(posedge clock) begin
      if (srst)
         done <= 1'b0;
      else
         done <= (avs_read | avs_write) & ~done;
   end
   // ----------------------------------------------------------------
   // control and configuration registers
   // ----------------------------------------------------------------
   integer i;
   always @(posedge clock) begin
      if (rst_all) begin
         ctrl          <= 8'h00;
         ch_index      <= 4'h0;
         user_mux      <= 16'h0000;
         router_enable <= 1'b0;
         en_ovr        <= {NCH{1'b0}};
         en_evd        <= {NCH{1'b0}};
         for (i = 0; i < NCH; i = i + 1) begin
            edge_r[i] <= `ECR_EDGE_NONE;
            path_r[i] <= `ECR_PATH_SYNC;
            gen_r[i]  <= 7'h00;
         end
      end else if (wr_ok) begin
         if (avs_address == `ECR_OFS_GLOBAL_CONTROL && prot_ok)
            ctrl <= {3'h0, wd[`ECR_BIT_CLOCK_POLICY], 4'h0};
         else if (avs_address == `ECR_OFS_ROUTER_ENABLE)
            router_enable <= (router_enable & ~avs_byteenable[0]) | wd[0];
         else if (avs_address == `ECR_OFS_USER_CHANNEL_MUX && prot_ok)
            user_mux <= (user_mux & ~wmask[15:0]) | (wd[15:0] & 16'h1f1f);
         else if (avs_address == `ECR_OFS_IRQ_ENABLE_SET) begin
            en_ovr <= en_ovr | wd_ovr;
            en_evd <= en_evd | wd_evd;
         end else if (avs_address == `ECR_OFS_IRQ_ENABLE_CLEAR) begin
            en_ovr <= en_ovr & ~wd_ovr;
            en_evd <= en_evd & ~wd_evd;
         end else if (cfg_wr && prot_ok) begin
            if (avs_byteenable[0])
               ch_index <= wr_idx;
            if (wr_idx < NCH) begin
               if (avs_byteenable[2])
                  gen_r[wr_idx] <= wd[`ECR_GEN_HI:`ECR_GEN_LO];
               if (avs_byteenable[3]) begin
                  edge_r[wr_idx] <= wd[`ECR_EDGE_HI:`ECR_EDGE_LO];
                  // reserved path code is refused
                  if (wd[`ECR_PATH_HI:`ECR_PATH_LO] != 2'h3)
                     path_r[wr_idx] <= wd[`ECR_PATH_HI:`ECR_PATH_LO];
               end
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // software event: one pulse on the indexed channel
   // ----------------------------------------------------------------
   wire [NCH-1:0] sw_evt;
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gen_ch
         wire gv = (gen_r[g] != 7'h00);
         assign sw_evt[g] = cfg_wr & prot_ok & avs_byteenable[1] &
                            wd[`ECR_BIT_SW_EVENT] & (wr_idx == g);
         ecr_channel u_ch (
            .clock                (clock),
            .srst                 (rst_all),
            .gen_sig              (gen_events[gen_r[g]]),
            .sw_event             (sw_evt[g]),
            .edge_select          (edge_r[g]),
            .path_select          (path_r[g]),
            .gen_valid            (gv),
            .clock_request_policy (ctrl[`ECR_BIT_CLOCK_POLICY]),
            .users_ready          (users_ready[g]),
            .users_ack            (users_ack[g]),
            .event_out            (channel_event[g]),
            .async_out            (channel_async[g]),
            .channel_busy         (busy[g]),
            .detect               (det[g]),
            .overrun              (overrun_flag[g]),
            .gclk_req             (gclk_request[g])
         );
      end
   endgenerate
   // ----------------------------------------------------------------
   // interrupt flags
   // ----------------------------------------------------------------
   // a read clears only the bits it reported, so an event after the snapshot survives;
   // a new event in the clearing cycle wins
   wire fl_rd = rd & (avs_address == `ECR_OFS_IRQ_PENDING);
   wire fl_wr = wr_ok & (avs_address == `ECR_OFS_IRQ_PENDING);
   wire [NCH-1:0] rd_ovr = {avs_readdata[19:16], avs_readdata[7:0]};
   wire [NCH-1:0] rd_evd = {avs_readdata[27:24], avs_readdata[15:8]};
   wire [NCH-1:0] clr_ovr = fl_rd ? rd_ovr : (fl_wr ? wd_ovr : {NCH{1'b0}});
   wire [NCH-1:0] clr_evd = fl_rd ? rd_evd : (fl_wr ? wd_evd : {NCH{1'b0}});
   always @(posedge clock) begin
      if (rst_all) begin
         fl_ovr <= {NCH{1'b0}};
         fl_evd <= {NCH{1'b0}};
      end else begin
         fl_ovr <= (fl_ovr & ~clr_ovr) | overrun_flag;
         fl_evd <= (fl_evd & ~clr_evd) | det;
      end
   end
   assign irq = |((fl_ovr & en_ovr) | (fl_evd & en_evd));
   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   wire [3:0] ri = (ch_index < NCH) ? ch_index : 4'h0;
   always @(posedge clock) begin
      if (srst)
         avs_readdata <= 32'h0000_0000;
      else if (rd_load) begin
         if (avs_address == `ECR_OFS_GLOBAL_CONTROL)
            avs_readdata <= {24'h0000_00, ctrl};
         else if (avs_address == `ECR_OFS_CHANNEL_CONFIG)
            avs_readdata <= {4'h0, edge_r[ri], path_r[ri], 1'b0, gen_r[ri],
                             8'h00, 4'h0, ch_index};
         else if (avs_address == `ECR_OFS_USER_CHANNEL_MUX)
            avs_readdata <= {16'h0000, user_mux};
         else if (avs_address == `ECR_OFS_CHANNEL_STATE)
            avs_readdata <= st_word;
         else if (avs_address == `ECR_OFS_IRQ_ENABLE_CLEAR ||
                  avs_address == `ECR_OFS_IRQ_ENABLE_SET)
            avs_readdata <= en_word;
         else if (avs_address == `ECR_OFS_IRQ_PENDING)
            avs_readdata <= fl_word;
         else if (avs_address == `ECR_OFS_ROUTER_ENABLE)
            avs_readdata <= {31'h0000_0000, router_enable};
         else
            avs_readdata <= 32'h0000_0000;
      end
   end
endmodule // ecr_router

// ==== ecr_router_checker.sv ====
// assertion checker for the router's bus handshake, soft reset and interrupt
`timescale 1ns/10ps
module ecr_router_checker #(
   parameter NCH  = 12,
   parameter NGEN = 128
) (
   input wire           clock,
   input wire           srst,
   input wire [4:0]     avs_address,
   input wire           avs_read,
   input wire           avs_write,
   input wire [3:0]     avs_byteenable,
   input wire [31:0]    avs_writedata,
   input wire [31:0]    avs_readdata,
   input wire           avs_waitrequest,
   input wire [NCH-1:0] gclk_request,
   input wire [NCH-1:0] channel_async,
   input wire           irq
);
   // ----------
   // shadow state
   // ----------
   wire        req = avs_read | avs_write;
   wire        wr  = avs_write & ~avs_waitrequest;
   wire [31:0] bm  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wm  = avs_writedata & bm;
   reg  [31:0] ien;
   reg         ren;
   // soft reset lands whatever the enable state
   wire soft_reset_trigger = wr & (avs_address == 5'h00) & wm[0];
   always @(posedge clock) begin
      if (srst | soft_reset_trigger) begin
         ien <= 32'h0000_0000;
         ren <= 1'b0;
      end else if (wr) begin
         if (avs_address == 5'h14) ien <= ien | wm;
         if (avs_address == 5'h10) ien <= ien & ~wm;
         if (avs_address == 5'h1c && avs_byteenable[0]) ren <= avs_writedata[0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_soft_reset_trigger; soft_reset_trigger; endsequence
   sequence s_soft_reset_trigger_pol; soft_reset_trigger ##0 avs_writedata[4]; endsequence
   property p_wait_first; req && !$past(req) |-> avs_waitrequest; endproperty
   property p_wait_bound; req |-> ##[0:1] !avs_waitrequest; endproperty
   property p_wait_again; req && !avs_waitrequest ##1 req |-> avs_waitrequest; endproperty
   property p_rd_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
   property p_soft_reset_trigger_clear; s_soft_reset_trigger |=> !irq && gclk_request == '0 && channel_async == '0;
   endproperty
   property p_soft_reset_trigger_only; s_soft_reset_trigger_pol |=> (gclk_request == '0)[*3]; endproperty
   property p_irq_mask; ien == 32'h0000_0000 |-> !irq; endproperty
   property p_irq_off; wr && avs_address == 5'h10 && wm == 32'hFFFF_FFFF |=> !irq; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");
   a_wait_bound: assert property (p_wait_bound) else $error("request never taken");
   a_wait_again: assert property (p_wait_again) else $error("second request not held");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_soft_reset_trigger_clear: assert property (p_soft_reset_trigger_clear) else $error("soft reset left state");
   a_soft_reset_trigger_only: assert property (p_soft_reset_trigger_only) else $error("policy kept on reset");
   a_irq_mask: assert property (p_irq_mask) else $error("irq with no enable");
   a_irq_off: assert property (p_irq_off) else $error("irq after enables cleared");
endmodule // ecr_router_checker
bind ecr_router ecr_router_checker #(.NCH(NCH), .NGEN(NGEN)) u_checker (
   .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .gclk_request(gclk_request), .channel_async(channel_async), .irq(irq));

// ==== ecr_partner.sv ====
// event user model: takes each channel event after a set delay
`timescale 1ns/10ps
module ecr_partner #(
   parameter NCH = 12
) (
   input  wire           clock,
   input  wire           srst,
   input  wire [NCH-1:0] channel_event,
   input  wire [3:0]     ack_delay,
   output reg  [NCH-1:0] users_ready,
   output reg  [NCH-1:0] users_ack
);
   // ----------
   // user handshake
   // ----------
   reg [3:0] wait_cnt [0:NCH-1];
   integer   i;
   // a slow user stays not ready until it has taken the event
   always @(posedge clock) begin
      for (i = 0; i < NCH; i = i + 1) begin
         users_ack[i] <= 1'b0;
         if (srst) begin
            users_ready[i] <= 1'b1;
            wait_cnt[i] <= 4'h0;
         end else if (channel_event[i]) begin
            users_ready[i] <= 1'b0;
            wait_cnt[i] <= ack_delay;
         end else if (!users_ready[i]) begin
            wait_cnt[i] <= wait_cnt[i] - 4'h1;
            users_ready[i] <= (wait_cnt[i] == 4'h0);
            users_ack[i] <= (wait_cnt[i] == 4'h0);
         end
      end
   end
endmodule // ecr_partner

// ==== test_event_channel_router_regs.sv ====
// self-checking bench for the event channel router registers and channels
`timescale 1ns/10ps
module test_event_channel_router_regs;
   reg          clock = 0, srst = 1, avs_read = 0, avs_write = 0;
   reg  [4:0]   avs_address = 5'h00;
   reg  [3:0]   avs_byteenable = 4'h0, ack_delay = 4'h1;
   reg  [31:0]  avs_writedata = 32'h0000_0000, q;
   reg  [127:0] gen_events = 128'h0;
   wire [31:0]  avs_readdata;
   wire         avs_waitrequest, irq;
   wire [11:0]  channel_event, channel_async, gclk_request, users_ready, users_ack;
   integer      num_errors = 0, num_checks = 0, cycles = 0, pulses = 0, e;
   // ----------
   // harness
   // ----------
   ecr_router DUT (.clock(clock), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .gen_events(gen_events), .users_ready(users_ready),
      .users_ack(users_ack), .channel_event(channel_event), .channel_async(channel_async),
      .gclk_request(gclk_request), .irq(irq));
   ecr_partner u_users (.clock(clock), .srst(srst), .channel_event(channel_event),
      .ack_delay(ack_delay), .users_ready(users_ready), .users_ack(users_ack));
   initial forever #4 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (channel_event[3]) pulses <= pulses + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         summarize;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // hold the request until waitrequest is seen low at a rising edge
   task bus(input we, input [4:0] a, input [3:0] be, input [31:0] d);
      begin
         avs_address <= a;
         avs_byteenable <= be;
         avs_writedata <= d;
         avs_write <= we;
         avs_read <= !we;
         @(posedge clock);
         while (avs_waitrequest) @(posedge clock);
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         // one idle edge so the next call never re-raises a strobe in this step
         @(posedge clock);
      end
   endtask
   task wr(input [4:0] a, input [3:0] be, input [31:0] d);
      bus(1'b1, a, be, d);
   endtask
   task rd(input [4:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 4'hf, 32'h0000_0000);
         chk(q, exp);
      end
   endtask
   task pulse_gen(input [6:0] g);
      begin
         gen_events[g] <= 1'b1;
         repeat (6) @(posedge clock);
         gen_events[g] <= 1'b0;
         repeat (6) @(posedge clock);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d errors %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // ----------
   // tests
   // ----------
   initial begin
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      for (e = 0; e < 8; e = e + 1)
         rd({e[2:0], 2'b00}, (e == 3) ? 32'h000F_00FF : 32'h0000_0000);
      rd(5'h01, 32'h0000_0000);
      $display("test reset values done");
      for (e = 0; e < 4; e = e + 1) begin
         wr(5'h04, 4'hf, {4'h0, e[1:0], 2'h0, 8'h05, 16'h0003});
         pulses = 0;
         pulse_gen(7'h05);
         chk(pulses, (e == 3) ? 2 : (e != 0));
      end
      rd(5'h04, 32'h0C05_0003);
      rd(5'h18, 32'h0000_0800);
      rd(5'h18, 32'h0000_0000);
      $display("test edge codes done");
      wr(5'h04, 4'hf, 32'h0405_0003);
      wr(5'h14, 4'h2, 32'h0000_0800);
      rd(5'h10, 32'h0000_0800);
      pulse_gen(7'h05);
      chk(irq, 1);
      wr(5'h18, 4'hf, 32'hFFFF_F7FF);
      chk(irq, 1);
      wr(5'h18, 4'hf, 32'h0000_0800);
      chk(irq, 0);
      wr(5'h10, 4'hf, 32'hFFFF_FFFF);
      rd(5'h14, 32'h0000_0000);
      $display("test interrupt done");
      chk(gclk_request, 12'h000);
      wr(5'h00, 4'h1, 32'h0000_0010);
      chk(gclk_request, 12'h008);
      ack_delay <= 4'hF;
      wr(5'h04, 4'h3, 32'h0000_0103);
      rd(5'h0c, 32'h000F_08F7);
      wr(5'h04, 4'h3, 32'h0000_0103);
      rd(5'h18, 32'h0000_0808);
      rd(5'h04, 32'h0405_0003);
      $display("test software event done");
      wr(5'h1c, 4'h1, 32'h0000_0001);
      wr(5'h00, 4'h1, 32'h0000_0000);
      rd(5'h00, 32'h0000_0010);
      wr(5'h1c, 4'h1, 32'h0000_0000);
      gen_events <= 128'h0;
      wr(5'h00, 4'h1, 32'h0000_0011);
      rd(5'h00, 32'h0000_0000);
      rd(5'h04, 32'h0000_0000);
      $display("test soft reset done");
      wr(5'h04, 4'hf, 32'h0206_0004);
      gen_events[6] <= 1'b1;
      repeat (3) @(posedge clock);
      chk(channel_async, 12'h010);
      chk(gclk_request, 12'h000);
      $display("test async path done");
      summarize;
   end
endmodule // test_event_channel_router_regs
